// ---- rtl/uefc_bus_dec.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "uefc_defines.svh"
module uefc_bus_dec
    import uefc_pkg::*;
(
    input  wire uefc_bus_req_t bus_req_in,
    output uefc_dec_t          dec_out
);
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    always_comb begin
        dec_out          = '0;
        dec_out.wr_idx   = bus_req_in.wr && hit(bus_req_in.addr, `UEFC_OFF_IDX);
        dec_out.wr_pkt   = bus_req_in.wr && hit(bus_req_in.addr, `UEFC_OFF_PKT);
        dec_out.wr_kind  = bus_req_in.wr && hit(bus_req_in.addr, `UEFC_OFF_KIND);
        dec_out.wr_len   = bus_req_in.wr && hit(bus_req_in.addr, `UEFC_OFF_LEN);
        dec_out.rd_idx   = bus_req_in.rd && hit(bus_req_in.addr, `UEFC_OFF_IDX);
        dec_out.rd_pkt   = bus_req_in.rd && hit(bus_req_in.addr, `UEFC_OFF_PKT);
        dec_out.rd_kind  = bus_req_in.rd && hit(bus_req_in.addr, `UEFC_OFF_KIND);
        dec_out.rd_len   = bus_req_in.rd && hit(bus_req_in.addr, `UEFC_OFF_LEN);
        dec_out.rd_alloc = bus_req_in.rd && hit(bus_req_in.addr, `UEFC_OFF_ALLOC);
    end
endmodule // uefc_bus_dec
`default_nettype wire

// ---- rtl/uefc_defines.svh ----
`ifndef UEFC_DEFINES_SVH
`define UEFC_DEFINES_SVH
// Summary of operation
// - Packet-size register applies to data endpoints only.
// - Writing packet size reloads current packet length.
// - Transactions field selects one to three packets.
// - FIFO size field sets endpoint bytes.
// - Null packet after DMA IN unless suppressed.
// - Enable bit activates endpoint FIFO allocation.
// - Disable then enable resets data PID.
// - Double buffer bit selects two buffers.
// - Endpoint kind: unused, isochronous, bulk, interrupt.
// - Current length holds size, bus reset clears.

`define UEFC_NUM_EP        16
`define UEFC_FIRST_DATA_EP 4'h3
`define UEFC_TOTAL_BYTES   15'h2000

`define UEFC_OFF_PKT       8'h04
`define UEFC_OFF_KIND      8'h08
`define UEFC_OFF_LEN       8'h1c
`define UEFC_OFF_IDX       8'h2c
`define UEFC_OFF_ALLOC     8'h3e

`define UEFC_FIFO_MSB      10
`define UEFC_TRANS_LSB     11
`define UEFC_TRANS_MSB     12
`define UEFC_KIND_MSB      4
`define UEFC_ENABLE_BIT    3
`define UEFC_DBL_BIT       2

`define UEFC_PKT_RST       13'h0000
`define UEFC_KIND_RST      5'h00
`define UEFC_LEN_RST       16'h0000
`define UEFC_IDX_RST       4'h0
`endif

// ---- rtl/uefc_pkg.sv ----
package uefc_pkg;
    typedef enum logic [1:0] {
        UEFC_KIND_UNUSED = 2'b00,
        UEFC_KIND_ISO    = 2'b01,
        UEFC_KIND_BULK   = 2'b10,
        UEFC_KIND_INTR   = 2'b11
    } uefc_kind_t;

    typedef struct packed {
        logic [1:0]  transactions_per_microframe;
        logic [10:0] fifo_size_bytes;
    } uefc_pkt_cfg_t;

    typedef struct packed {
        logic       suppress_null_packet;
        logic       enable;
        logic       double_buffer_enable;
        uefc_kind_t endpoint_kind;
    } uefc_kind_cfg_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } uefc_bus_req_t;

    typedef struct packed {
        logic wr_idx;
        logic wr_pkt;
        logic wr_kind;
        logic wr_len;
        logic rd_idx;
        logic rd_pkt;
        logic rd_kind;
        logic rd_len;
        logic rd_alloc;
    } uefc_dec_t;

    typedef struct packed {
        uefc_pkt_cfg_t  pkt;
        uefc_kind_cfg_t kind;
        logic [1:0]     trans_count;
        logic [15:0]    current_packet_length;
    } uefc_sie_cfg_t;
endpackage

// ---- rtl/uefc_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "uefc_defines.svh"
module uefc_top
    import uefc_pkg::*;
(
    input  wire logic          clk_sys_in,
    input  wire logic          resetn_in,
    input  wire logic          usb_bus_reset_in,
    input  wire logic          hs_mode_in,
    input  wire uefc_bus_req_t bus_req_in,
    output logic [15:0]        rdata_out,
    output logic               rvalid_out,
    input  wire logic [3:0]    sie_ep_in,
    output uefc_sie_cfg_t      sie_cfg_out,
    output logic [15:0]        ep_enable_out,
    output logic [15:0]        ep_double_buf_out,
    output logic [15:0]        pid_reset_out,
    output logic [14:0]        alloc_bytes_out,
    input  wire logic          dma_in_done_in,
    input  wire logic [3:0]    dma_ep_in,
    input  wire logic          in_token_in,
    input  wire logic [3:0]    token_ep_in,
    output logic               zlp_send_out,
    output logic [3:0]         zlp_ep_out
);
    localparam int NEP = `UEFC_NUM_EP;

    uefc_dec_t      dec;
    logic [3:0]     idx_reg;
    logic [3:0]     idx_next;
    uefc_pkt_cfg_t  pkt_reg  [NEP];
    uefc_pkt_cfg_t  pkt_next [NEP];
    uefc_kind_cfg_t kind_reg [NEP];
    uefc_kind_cfg_t kind_next[NEP];
    logic [15:0]    len_reg  [NEP];
    logic [15:0]    len_next [NEP];
    logic [15:0]    rdata_reg;
    logic [15:0]    rdata_next;
    logic           rvalid_reg;
    logic           rvalid_next;
    uefc_sie_cfg_t  sie_reg;
    uefc_sie_cfg_t  sie_next;
    logic [15:0]    ena_reg;
    logic [15:0]    ena_next;
    logic [15:0]    dbl_reg;
    logic [15:0]    dbl_next;
    logic [15:0]    pid_reg;
    logic [15:0]    pid_next;
    logic [14:0]    alloc_reg;
    logic [14:0]    alloc_next;
    logic [15:0]    suppress_vec;

    // Setup buffer and both control endpoints sit below the first data index.
    function automatic logic data_ep(input logic [3:0] idx);
        data_ep = (idx >= `UEFC_FIRST_DATA_EP);
    endfunction

    // Packets per microframe; anything but high-speed periodic traffic gets one.
    function automatic logic [1:0] trans_count(input uefc_pkt_cfg_t p, input uefc_kind_cfg_t k,
                                               input logic hs);
        trans_count = 2'h1;
        if (hs && (k.endpoint_kind == UEFC_KIND_ISO || k.endpoint_kind == UEFC_KIND_INTR)) begin
            case (p.transactions_per_microframe)
                2'b00:   trans_count = 2'h1;
                2'b01:   trans_count = 2'h2;
                2'b10:   trans_count = 2'h3;
                default: trans_count = 2'h1;
            endcase
        end
    endfunction

    uefc_bus_dec u_dec (
        .bus_req_in (bus_req_in),
        .dec_out    (dec)
    );

    always_comb begin
        for (int i = 0; i < NEP; i++) begin
            suppress_vec[i] = kind_reg[i].suppress_null_packet;
        end
    end

    uefc_zlp_gen u_zlp (
        .clk_sys_in       (clk_sys_in),
        .resetn_in        (resetn_in),
        .usb_bus_reset_in (usb_bus_reset_in),
        .suppress_in      (suppress_vec),
        .dma_in_done_in   (dma_in_done_in),
        .dma_ep_in        (dma_ep_in),
        .in_token_in      (in_token_in),
        .token_ep_in      (token_ep_in),
        .zlp_send_out     (zlp_send_out),
        .zlp_ep_out       (zlp_ep_out)
    );

    // Endpoint register writes always target the endpoint that the index register selects.
    always_comb begin
        idx_next  = idx_reg;
        pkt_next  = pkt_reg;
        kind_next = kind_reg;
        len_next  = len_reg;
        if (dec.wr_idx) begin
            idx_next = bus_req_in.wdata[3:0];
        end
        if (dec.wr_pkt && data_ep(idx_reg)) begin
            pkt_next[idx_reg] = uefc_pkt_cfg_t'(bus_req_in.wdata[`UEFC_TRANS_MSB:0]);
            len_next[idx_reg] = {5'h00, bus_req_in.wdata[`UEFC_FIFO_MSB:0]};
        end
        if (dec.wr_kind) begin
            kind_next[idx_reg] = uefc_kind_cfg_t'(bus_req_in.wdata[`UEFC_KIND_MSB:0]);
        end
        if (dec.wr_len) begin
            len_next[idx_reg] = bus_req_in.wdata;
        end
        if (usb_bus_reset_in) begin
            pkt_next  = '{default: `UEFC_PKT_RST};
            kind_next = '{default: `UEFC_KIND_RST};
            len_next  = '{default: `UEFC_LEN_RST};
        end
    end

    // Enable, buffering and allocation follow the values being committed this cycle.
    always_comb begin
        alloc_next = 15'h0000;
        for (int i = 0; i < NEP; i++) begin
            ena_next[i] = kind_next[i].enable;
            dbl_next[i] = kind_next[i].double_buffer_enable;
            pid_next[i] = !kind_reg[i].enable && kind_next[i].enable;
            if (kind_next[i].enable && data_ep(4'(i))) begin
                alloc_next = alloc_next + 15'(pkt_next[i].fifo_size_bytes);
            end
        end
    end

    // Reads return the selected endpoint or the allocation total; unmapped offsets return zero.
    always_comb begin
        rvalid_next = bus_req_in.rd;
        rdata_next  = 16'h0000;
        if (dec.rd_idx) begin
            rdata_next = {12'h000, idx_reg};
        end
        if (dec.rd_pkt) begin
            rdata_next = {3'h0, pkt_reg[idx_reg]};
        end
        if (dec.rd_kind) begin
            rdata_next = {11'h000, kind_reg[idx_reg]};
        end
        if (dec.rd_len) begin
            rdata_next = len_reg[idx_reg];
        end
        if (dec.rd_alloc) begin
            rdata_next = {1'b0, alloc_reg};
        end
    end

    always_comb begin
        sie_next.pkt                   = pkt_reg[sie_ep_in];
        sie_next.kind                  = kind_reg[sie_ep_in];
        sie_next.trans_count           = trans_count(pkt_reg[sie_ep_in], kind_reg[sie_ep_in],
                                                     hs_mode_in);
        sie_next.current_packet_length = len_reg[sie_ep_in];
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            idx_reg    <= `UEFC_IDX_RST;
            pkt_reg    <= '{default: `UEFC_PKT_RST};
            kind_reg   <= '{default: `UEFC_KIND_RST};
            len_reg    <= '{default: `UEFC_LEN_RST};
            rdata_reg  <= 16'h0000;
            rvalid_reg <= 1'b0;
            sie_reg    <= '0;
            ena_reg    <= 16'h0000;
            dbl_reg    <= 16'h0000;
            pid_reg    <= 16'h0000;
            alloc_reg  <= 15'h0000;
        end else begin
            idx_reg    <= idx_next;
            pkt_reg    <= pkt_next;
            kind_reg   <= kind_next;
            len_reg    <= len_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
            sie_reg    <= sie_next;
            ena_reg    <= ena_next;
            dbl_reg    <= dbl_next;
            pid_reg    <= pid_next;
            alloc_reg  <= alloc_next;
        end
    end

    assign rdata_out         = rdata_reg;
    assign rvalid_out        = rvalid_reg;
    assign sie_cfg_out       = sie_reg;
    assign ep_enable_out     = ena_reg;
    assign ep_double_buf_out = dbl_reg;
    assign pid_reset_out     = pid_reg;
    assign alloc_bytes_out   = alloc_reg;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!resetn_in);

    sequence s_pkt_wr;
        dec.wr_pkt && data_ep(idx_reg) && !usb_bus_reset_in;
    endsequence

    sequence s_reenable;
        dec.wr_kind && !kind_reg[idx_reg].enable && bus_req_in.wdata[`UEFC_ENABLE_BIT] && !usb_bus_reset_in;
    endsequence

    sequence s_kind_rd;
        dec.rd_kind;
    endsequence

    sequence s_pkt_rd;
        dec.rd_pkt;
    endsequence

    a_len_reload: assert property (
        s_pkt_wr |=> len_reg[$past(idx_reg)] == {5'h00, $past(bus_req_in.wdata[10:0])})
        else $error("Current length not reloaded from FIFO size.");

    a_size_field: assert property (
        s_pkt_wr ##1 dec.rd_pkt && idx_reg == $past(idx_reg) && !usb_bus_reset_in
        |=> rdata_out[10:0] == $past(bus_req_in.wdata[10:0], 2))
        else $error("FIFO size field not read back.");

    a_ctrl_ignore: assert property (
        (dec.wr_pkt && !data_ep(idx_reg)) |=> pkt_reg[$past(idx_reg)] == 13'h0000)
        else $error("Control endpoint took a packet size.");

    a_busrst_clear: assert property (
        usb_bus_reset_in |=> len_reg[idx_reg] == 16'h0000 && kind_reg[idx_reg] == 5'h00
                             && pkt_reg[idx_reg] == 13'h0000)
        else $error("Bus reset left state behind.");

    a_rsv_zero: assert property (
        s_kind_rd |=> rvalid_out && rdata_out[15:5] == 11'h000)
        else $error("Reserved kind bits read nonzero.");

    a_pid_reset: assert property (
        s_reenable |=> pid_reset_out[$past(idx_reg)] ##1 !pid_reset_out[$past(idx_reg, 2)])
        else $error("Data PID reset not pulsed on re-enable.");

    a_enable_out: assert property (
        (dec.wr_kind && !usb_bus_reset_in)
        |=> ep_enable_out[$past(idx_reg)] == $past(bus_req_in.wdata[`UEFC_ENABLE_BIT]))
        else $error("Enable output does not follow write.");

    a_dbl_out: assert property (
        (dec.wr_kind && !usb_bus_reset_in)
        |=> ep_double_buf_out[$past(idx_reg)] == $past(bus_req_in.wdata[`UEFC_DBL_BIT]))
        else $error("Double buffer output does not follow write.");

    a_kind_code: assert property (
        (dec.wr_kind && !usb_bus_reset_in) |=> kind_reg[$past(idx_reg)].endpoint_kind
                                               == uefc_kind_t'($past(bus_req_in.wdata[1:0])))
        else $error("Endpoint kind not stored.");

    a_trans_map: assert property (
        ($past(hs_mode_in) && sie_cfg_out.kind.endpoint_kind == UEFC_KIND_ISO
         && sie_cfg_out.pkt.transactions_per_microframe == 2'b10) |-> sie_cfg_out.trans_count == 2'h3)
        else $error("Three transactions not selected.");

    a_trans_fs: assert property (
        !$past(hs_mode_in) |-> sie_cfg_out.trans_count == 2'h1)
        else $error("Full speed must use one transaction.");

    a_trans_bulk: assert property (
        ($past(hs_mode_in) && sie_cfg_out.kind.endpoint_kind == UEFC_KIND_BULK)
        |-> sie_cfg_out.trans_count == 2'h1)
        else $error("Bulk endpoint must use one transaction.");

    a_len_write: assert property (
        (dec.wr_len && !usb_bus_reset_in) |=> len_reg[$past(idx_reg)] == $past(bus_req_in.wdata))
        else $error("Current length write not stored.");

    a_rsv_size: assert property (
        s_pkt_rd |=> rvalid_out && rdata_out[15:13] == 3'h0)
        else $error("Reserved size bits read nonzero.");

    a_pid_quiet: assert property (
        (dec.wr_kind && kind_reg[idx_reg].enable) |=> !pid_reset_out[$past(idx_reg)])
        else $error("Data PID reset pulsed without re-enable.");

    a_ena_hold: assert property (
        (!dec.wr_kind && !usb_bus_reset_in) |=> ep_enable_out == $past(ep_enable_out))
        else $error("Enable output changed without a write.");

    a_busrst_outs: assert property (
        usb_bus_reset_in |=> ep_enable_out == 16'h0000 && ep_double_buf_out == 16'h0000
                             && alloc_bytes_out == 15'h0000)
        else $error("Bus reset left outputs set.");

    a_busrst_zlp: assert property (
        usb_bus_reset_in |=> !zlp_send_out)
        else $error("Null packet sent after bus reset.");

    a_idx_kept: assert property (
        (usb_bus_reset_in && !dec.wr_idx) |=> idx_reg == $past(idx_reg))
        else $error("Bus reset changed the endpoint index.");

    a_rd_answer: assert property (
        bus_req_in.rd |=> rvalid_out)
        else $error("Read not answered in one cycle.");
endmodule // uefc_top
`default_nettype wire

// ---- rtl/uefc_zlp_gen.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "uefc_defines.svh"
module uefc_zlp_gen
    import uefc_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    input  wire logic        usb_bus_reset_in,
    input  wire logic [15:0] suppress_in,
    input  wire logic        dma_in_done_in,
    input  wire logic [3:0]  dma_ep_in,
    input  wire logic        in_token_in,
    input  wire logic [3:0]  token_ep_in,
    output logic             zlp_send_out,
    output logic [3:0]       zlp_ep_out
);
    logic [15:0] pending_reg;
    logic [15:0] pending_next;
    logic        send_reg;
    logic        send_next;
    logic [3:0]  ep_reg;
    logic [3:0]  ep_next;

    // The suppress bit is looked at again when the token comes, so setting it late still wins; clearing it late sends nothing.
    always_comb begin
        pending_next = pending_reg;
        send_next    = 1'b0;
        ep_next      = ep_reg;
        if (in_token_in && pending_reg[token_ep_in]) begin
            pending_next[token_ep_in] = 1'b0;
            send_next                 = !suppress_in[token_ep_in];
            ep_next                   = token_ep_in;
        end
        if (dma_in_done_in && !suppress_in[dma_ep_in]) begin
            pending_next[dma_ep_in] = 1'b1;
        end
        if (usb_bus_reset_in) begin
            pending_next = 16'h0000;
            send_next    = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!resetn_in) begin
            pending_reg <= 16'h0000;
            send_reg    <= 1'b0;
            ep_reg      <= 4'h0;
        end else begin
            pending_reg <= pending_next;
            send_reg    <= send_next;
            ep_reg      <= ep_next;
        end
    end

    assign zlp_send_out = send_reg;
    assign zlp_ep_out   = ep_reg;

    a_zlp_sent: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (in_token_in && pending_reg[token_ep_in] && !suppress_in[token_ep_in] && !usb_bus_reset_in)
        |=> zlp_send_out && zlp_ep_out == $past(token_ep_in))
        else $error("Null packet not sent on IN token.");
    a_zlp_quiet: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (in_token_in && suppress_in[token_ep_in]) |=> !zlp_send_out)
        else $error("Null packet sent while suppressed.");
endmodule // uefc_zlp_gen
`default_nettype wire

// ---- verification/uefc_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench
    import uefc_pkg::*;
;
    logic          clk_sys_in;
    logic          resetn_in;
    logic          usb_bus_reset_in;
    logic          hs_mode_in;
    uefc_bus_req_t bus_req;
    logic [15:0]   rdata_out;
    logic          rvalid_out;
    logic [3:0]    sie_ep_in;
    uefc_sie_cfg_t sie_cfg_out;
    logic [15:0]   ep_enable_out;
    logic [15:0]   ep_double_buf_out;
    logic [15:0]   pid_reset_out;
    logic [14:0]   alloc_bytes_out;
    logic          dma_in_done_in;
    logic [3:0]    dma_ep_in;
    logic          in_token_in;
    logic [3:0]    token_ep_in;
    logic          zlp_send_out;
    logic [3:0]    zlp_ep_out;
    int            err_total;
    int            total_checks;
    int            pid_cnt;
    int            zlp_cnt;
    logic [3:0]    zlp_ep_seen;

    uefc_top uefc_top_inst (
        .clk_sys_in        (clk_sys_in),
        .resetn_in         (resetn_in),
        .usb_bus_reset_in  (usb_bus_reset_in),
        .hs_mode_in        (hs_mode_in),
        .bus_req_in        (bus_req),
        .rdata_out         (rdata_out),
        .rvalid_out        (rvalid_out),
        .sie_ep_in         (sie_ep_in),
        .sie_cfg_out       (sie_cfg_out),
        .ep_enable_out     (ep_enable_out),
        .ep_double_buf_out (ep_double_buf_out),
        .pid_reset_out     (pid_reset_out),
        .alloc_bytes_out   (alloc_bytes_out),
        .dma_in_done_in    (dma_in_done_in),
        .dma_ep_in         (dma_ep_in),
        .in_token_in       (in_token_in),
        .token_ep_in       (token_ep_in),
        .zlp_send_out      (zlp_send_out),
        .zlp_ep_out        (zlp_ep_out)
    );

    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    // Pulses are counted at every rising edge so that the exact cycle of a pulse does not matter.
    always @(posedge clk_sys_in) begin
        if (resetn_in === 1'b1) begin
            if (pid_reset_out[5] === 1'b1) pid_cnt++;
            if (zlp_send_out === 1'b1) begin
                zlp_cnt++;
                zlp_ep_seen = zlp_ep_out;
            end
        end
    end

    task automatic close_out();
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys_in);
        bus_req <= '0;
    endtask

    task automatic bus_rd(input logic [7:0] a, input logic [15:0] exp);
        int n;
        @(posedge clk_sys_in);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk_sys_in);
        bus_req <= '0;
        n = 0;
        @(negedge clk_sys_in);
        while (rvalid_out !== 1'b1 && n < 4) begin
            @(negedge clk_sys_in);
            n++;
        end
        chk_val(rdata_out, exp);
    endtask

    task automatic bus_wr_rd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] exp);
        @(posedge clk_sys_in);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys_in);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk_sys_in);
        bus_req <= '0;
        @(negedge clk_sys_in);
        chk_val(rdata_out, exp);
    endtask

    task automatic settle();
        repeat (3) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
    endtask

    task automatic zlp_try(input int exp_cnt);
        @(posedge clk_sys_in);
        dma_in_done_in <= 1'b1;
        @(posedge clk_sys_in);
        dma_in_done_in <= 1'b0;
        in_token_in    <= 1'b1;
        @(posedge clk_sys_in);
        in_token_in    <= 1'b0;
        settle();
        chk_val(16'(zlp_cnt), 16'(exp_cnt));
    endtask

    initial begin
        #50us;
        err_total++;
        close_out();
    end

    initial begin
        resetn_in        = 1'b0;
        usb_bus_reset_in = 1'b0;
        hs_mode_in       = 1'b1;
        bus_req          = '0;
        sie_ep_in        = 4'h5;
        dma_in_done_in   = 1'b0;
        dma_ep_in        = 4'h5;
        in_token_in      = 1'b0;
        token_ep_in      = 4'h5;
        err_total        = 0;
        total_checks     = 0;
        pid_cnt          = 0;
        zlp_cnt          = 0;
        zlp_ep_seen      = 4'h0;
        repeat (4) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        bus_wr(8'h2c, 16'h0005);
        bus_rd(8'h04, 16'h0000);
        bus_rd(8'h08, 16'h0000);
        bus_rd(8'h1c, 16'h0000);
        bus_rd(8'h10, 16'h0000);
        bus_wr_rd(8'h04, 16'he840, 16'h0840);
        bus_rd(8'h1c, 16'h0040);
        bus_wr(8'h1c, 16'h0012);
        bus_rd(8'h1c, 16'h0012);
        bus_wr(8'h04, 16'h0840);
        bus_rd(8'h1c, 16'h0040);
        bus_wr(8'h2c, 16'h0001);
        bus_wr(8'h04, 16'h0123);
        bus_rd(8'h04, 16'h0000);
        bus_wr(8'h2c, 16'h0005);
        bus_wr(8'h08, 16'hffe1);
        bus_rd(8'h08, 16'h0001);
        bus_wr(8'h08, 16'h000d);
        settle();
        chk_val(16'(ep_enable_out[5]), 16'h0001);
        chk_val(16'(alloc_bytes_out), 16'h0040);
        chk_val(16'(pid_cnt), 16'h0001);
        bus_rd(8'h3e, 16'h0040);
        for (int k = 0; k < 4; k++) begin
            bus_wr(8'h08, 16'h0008 | 16'(k));
            settle();
            chk_val(16'(sie_cfg_out.kind.endpoint_kind), 16'(k));
        end
        chk_val(16'(pid_cnt), 16'h0001);
        // Transaction count is only meaningful for a periodic endpoint, so isochronous is set first.
        bus_wr(8'h08, 16'h000d);
        for (int t = 0; t < 3; t++) begin
            bus_wr(8'h04, (16'(t) << 11) | 16'h0040);
            settle();
            chk_val(16'(sie_cfg_out.trans_count), 16'(t + 1));
            chk_val(16'(sie_cfg_out.pkt.transactions_per_microframe), 16'(t));
        end
        @(posedge clk_sys_in);
        hs_mode_in <= 1'b0;
        settle();
        chk_val(16'(sie_cfg_out.trans_count), 16'h0001);
        @(posedge clk_sys_in);
        hs_mode_in <= 1'b1;
        bus_wr(8'h08, 16'h0001);
        settle();
        chk_val(16'(ep_enable_out[5]), 16'h0000);
        chk_val(16'(alloc_bytes_out), 16'h0000);
        chk_val(16'(ep_double_buf_out[5]), 16'h0000);
        bus_wr(8'h08, 16'h000e);
        settle();
        chk_val(16'(pid_cnt), 16'h0002);
        chk_val(16'(ep_double_buf_out[5]), 16'h0001);
        zlp_try(1);
        chk_val(16'(zlp_ep_seen), 16'h0005);
        bus_wr(8'h08, 16'h001e);
        zlp_try(1);
        @(posedge clk_sys_in);
        usb_bus_reset_in <= 1'b1;
        @(posedge clk_sys_in);
        usb_bus_reset_in <= 1'b0;
        settle();
        chk_val(16'(ep_enable_out[5]), 16'h0000);
        bus_rd(8'h04, 16'h0000);
        bus_rd(8'h08, 16'h0000);
        bus_rd(8'h1c, 16'h0000);
        bus_rd(8'h2c, 16'h0005);
        bus_wr(8'h08, 16'h000f);
        @(posedge clk_sys_in);
        resetn_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        bus_rd(8'h2c, 16'h0000);
        chk_val(16'(pid_cnt), 16'h0003);
        bus_wr(8'h2c, 16'h0005);
        bus_rd(8'h08, 16'h0000);
        chk_val(16'(ep_enable_out[5]), 16'h0000);
        close_out();
    end
endmodule // testbench
`default_nettype wire
